// *** hw/energy_accum_input_select.sv ***
// accumulator input selection: wiring topology, reactive sign mode, reversal flags
// assumes samples and update strobe come from logic on clk_sys_in; registers on a plain strobe port
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "accum_sel_consts.svh"

// Operation
// [RULE_01] reserved reactive mode codes behave exactly like signed accumulation
// [RULE_02] sign-dependent mode negates reactive power while matching active power is negative
// [RULE_03] reactive mode field bits 3:2, reset zero, zero means signed accumulation
// [RULE_04] connection select bits 5:4, reset zero, choose products feeding accumulators
// [RULE_05] reactive inputs use voltage times quarter-period delayed current
// [RULE_06] codes: 00 wye three sensors, 01 delta three wire, 10 wye two, 11 delta four
// [RULE_07] phases a and c always use their own products
// [RULE_08] three-wire delta feeds zero to every phase b accumulator
// [RULE_09] two-sensor wye uses minus (va plus vc) as phase b voltage
// [RULE_10] four-wire delta uses minus va as phase b voltage
// [RULE_11] bit 6 picks total or fundamental active power for status bits 6..8
// [RULE_12] bit 7 picks total or fundamental reactive power for status bits 10..12
// [RULE_13] selection changes apply at next update and never clear accumulated energy
module energy_accum_input_select
  import accum_sel_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      rstn_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic      reg_wr_in,
  input  wire logic      reg_rd_in,
  output var  logic [15:0] reg_rdata_out,
  output var  logic      irq_out,
  input  wire logic      sample_upd_in,
  input  wire sample_t   volt_in       [3],
  input  wire sample_t   cur_in        [3],
  input  wire sample_t   cur_shift_in  [3],
  input  wire sample_t   fvolt_in      [3],
  input  wire sample_t   fcur_in       [3],
  input  wire sample_t   fcur_shift_in [3],
  input  wire rms_t      vrms_in       [3],
  input  wire rms_t      irms_in       [3],
  output var  logic      energy_upd_out,
  output var  power_t    watt_inc_out     [3],
  output var  power_t    fwatt_inc_out    [3],
  output var  power_t    react_inc_out    [3],
  output var  power_t    freact_inc_out   [3],
  output var  apparent_t apparent_inc_out [3]
);

  // =====================================================
  // configuration and status registers
  logic [7:0]            cfg_reg;
  logic [15:0]           status_reg;
  logic [15:0]           status_next;
  logic [15:0]           mask_reg;
  logic [15:0]           mask_next;
  logic [15:0]           status_set;
  logic [15:0]           status_clr;
  logic [15:0]           rdata_next;
  logic                  irq_reg;
  connection_select_t    consel_cur;
  connection_select_t    consel_s1_reg;
  reactive_accum_mode_t  var_mode;
  logic                  revap_sel;
  logic                  revrp_sel;
  logic                  s2_fire;

  assign consel_cur = connection_select_t'(cfg_reg[`CFG_CONSEL_MSB:`CFG_CONSEL_LSB]);
  assign var_mode   = reactive_accum_mode_t'(cfg_reg[`CFG_VAR_MSB:`CFG_VAR_LSB]);
  assign revap_sel  = cfg_reg[`CFG_REVAP_BIT];
  assign revrp_sel  = cfg_reg[`CFG_REVRP_BIT];

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_reg <= `CFG_RESET; // RULE_03 RULE_04
    end else if (reg_wr_in && reg_addr_in == `ADDR_ACCUM_MODE_CFG) begin
      cfg_reg <= reg_wdata_in[7:0]; // RULE_04 RULE_13
    end
  end

  always_comb begin
    status_clr = '0;
    if (reg_wr_in && reg_addr_in == `ADDR_PRIMARY_STATUS) begin
      status_clr = reg_wdata_in;
    end
    status_next = ((status_reg & ~status_clr) | status_set) & `STATUS_IMPL_MASK;
    mask_next   = mask_reg;
    if (reg_wr_in && reg_addr_in == `ADDR_STATUS_MASK) begin
      mask_next = reg_wdata_in & `STATUS_IMPL_MASK;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg <= `STATUS_RESET;
      mask_reg   <= `MASK_RESET;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask_next);
    end
  end

  assign irq_out = irq_reg;

  // =====================================================
  // register read port
  always_comb begin
    rdata_next = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `ADDR_ACCUM_MODE_CFG: rdata_next = {8'h00, cfg_reg};
        `ADDR_PRIMARY_STATUS: rdata_next = status_reg;
        `ADDR_STATUS_MASK:    rdata_next = mask_reg;
        default:              rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

  // =====================================================
  // voltage selection per wiring topology
  function automatic volt_ext_t ext_volt(input sample_t s);
    return {{2{s[15]}}, s};
  endfunction

  function automatic volt_ext_t pick_volt(input connection_select_t cs, input int ph,
                                          input sample_t a, input sample_t b, input sample_t c);
    volt_ext_t r;
    r = ext_volt(b);
    if (ph == 0) begin
      r = ext_volt(a); // RULE_07
    end else if (ph == 2) begin
      r = ext_volt(c); // RULE_07
    end else begin
      case (cs) // RULE_06
        CONSEL_WYE_2SENSOR: r = -(ext_volt(a) + ext_volt(c)); // RULE_09
        CONSEL_DELTA_4WIRE: r = -ext_volt(a); // RULE_10
        default:            r = ext_volt(b);
      endcase
    end
    return r;
  endfunction

  // =====================================================
  // per-phase products and fed values
  wire volt_ext_t  volt_sel   [3];
  wire power_t     watt_tot   [3];
  wire power_t     react_tot  [3];
  wire power_t     fwatt_tot  [3];
  wire power_t     freact_tot [3];
  wire power_t     watt_fed   [3];
  wire power_t     react_fed  [3];
  wire power_t     fwatt_fed  [3];
  wire power_t     freact_fed [3];
  wire power_t     react_acc  [3];
  wire power_t     freact_acc [3];
  wire apparent_t  app_fed    [3];
  wire logic [2:0] vld_tot;
  wire logic [2:0] rev_ap;
  wire logic [2:0] rev_rp;
  wire logic [2:0] ap_sign;
  wire logic [2:0] rp_sign;
  apparent_t       app_s1_reg [3];
  logic [2:0]      ap_prev_reg;
  logic [2:0]      rp_prev_reg;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      phase_power_if pp_tot ();
      phase_power_if pp_fund ();
      logic zero_b;

      assign volt_sel[g]   = pick_volt(consel_cur, g, volt_in[0], volt_in[1], volt_in[2]);
      assign pp_tot.upd    = sample_upd_in;
      assign pp_tot.v      = volt_sel[g];
      assign pp_tot.i      = cur_in[g];
      assign pp_tot.iq     = cur_shift_in[g]; // RULE_05
      assign pp_fund.upd   = sample_upd_in;
      assign pp_fund.v     = pick_volt(consel_cur, g, fvolt_in[0], fvolt_in[1], fvolt_in[2]);
      assign pp_fund.i     = fcur_in[g];
      assign pp_fund.iq    = fcur_shift_in[g]; // RULE_05

      phase_power_calc u_tot (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .pp         (pp_tot)
      );

      phase_power_calc u_fund (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .pp         (pp_fund)
      );

      assign watt_tot[g]   = pp_tot.watt;
      assign react_tot[g]  = pp_tot.react;
      assign fwatt_tot[g]  = pp_fund.watt;
      assign freact_tot[g] = pp_fund.react;
      assign vld_tot[g]    = pp_tot.vld;

      assign zero_b        = (g == 1) && (consel_s1_reg == CONSEL_DELTA_3WIRE); // RULE_08
      assign watt_fed[g]   = zero_b ? '0 : watt_tot[g];
      assign fwatt_fed[g]  = zero_b ? '0 : fwatt_tot[g];
      assign react_fed[g]  = zero_b ? '0 : react_tot[g];
      assign freact_fed[g] = zero_b ? '0 : freact_tot[g];
      assign app_fed[g]    = zero_b ? '0 : app_s1_reg[g];

      assign react_acc[g]  = (var_mode == VARACC_BY_SIGN && watt_fed[g][33]) ? -react_fed[g] : react_fed[g]; // RULE_01 RULE_02 RULE_03
      assign freact_acc[g] = (var_mode == VARACC_BY_SIGN && fwatt_fed[g][33]) ? -freact_fed[g] : freact_fed[g]; // RULE_02

      assign ap_sign[g]    = revap_sel ? fwatt_fed[g][33] : watt_fed[g][33]; // RULE_11
      assign rp_sign[g]    = revrp_sel ? freact_fed[g][33] : react_fed[g][33]; // RULE_12
      assign rev_ap[g]     = s2_fire && (ap_sign[g] != ap_prev_reg[g]);
      assign rev_rp[g]     = s2_fire && (rp_sign[g] != rp_prev_reg[g]);
    end
  endgenerate

  assign s2_fire    = vld_tot[0];
  assign status_set = (16'(rev_ap) << `STATUS_REVAP_A_BIT) | (16'(rev_rp) << `STATUS_REVRP_A_BIT); // RULE_11 RULE_12

  // =====================================================
  // stage one: topology latch and apparent product
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      consel_s1_reg <= CONSEL_WYE_3SENSOR;
      for (int p = 0; p < 3; p++) begin
        app_s1_reg[p] <= '0;
      end
    end else if (sample_upd_in) begin
      consel_s1_reg <= consel_cur; // RULE_13
      for (int p = 0; p < 3; p++) begin
        app_s1_reg[p] <= apparent_t'(vrms_in[p]) * apparent_t'(irms_in[p]);
      end
    end
  end

  // =====================================================
  // stage two: accumulator increments and reversal history
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ap_prev_reg <= '0;
      rp_prev_reg <= '0;
      for (int p = 0; p < 3; p++) begin
        watt_inc_out[p]     <= '0;
        fwatt_inc_out[p]    <= '0;
        react_inc_out[p]    <= '0;
        freact_inc_out[p]   <= '0;
        apparent_inc_out[p] <= '0;
      end
    end else if (s2_fire) begin
      ap_prev_reg <= ap_sign;
      rp_prev_reg <= rp_sign;
      for (int p = 0; p < 3; p++) begin
        watt_inc_out[p]     <= watt_fed[p]; // RULE_07
        fwatt_inc_out[p]    <= fwatt_fed[p];
        react_inc_out[p]    <= react_acc[p];
        freact_inc_out[p]   <= freact_acc[p];
        apparent_inc_out[p] <= app_fed[p];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      energy_upd_out <= 1'b0;
    end else begin
      energy_upd_out <= s2_fire;
    end
  end

  // =====================================================
  // checks
  chk_reserved_var_signed: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_01
    (s2_fire && (var_mode == VARACC_RSV_1 || var_mode == VARACC_RSV_3)) |=> react_inc_out[0] == $past(react_tot[0]))
    else $error("reserved reactive mode did not accumulate signed");

  chk_sign_negate_var: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_02
    (s2_fire && var_mode == VARACC_BY_SIGN && fwatt_tot[2][33]) |=> freact_inc_out[2] == -$past(freact_tot[2]))
    else $error("fundamental reactive power not negated for negative active power");

  chk_default_var_signed: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_03
    (s2_fire && var_mode == VARACC_SIGNED) |=> react_inc_out[2] == $past(react_tot[2]))
    else $error("default reactive mode changed sign");

  chk_consel_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_04
    (reg_wr_in && reg_addr_in == `ADDR_ACCUM_MODE_CFG) |=> consel_cur == $past(reg_wdata_in[`CFG_CONSEL_MSB:`CFG_CONSEL_LSB]))
    else $error("connection select not written");

  chk_quarter_shift_var: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_05
    sample_upd_in |=> react_tot[0] == $past(volt_sel[0]) * $past(cur_shift_in[0]))
    else $error("reactive product not from shifted current");

  chk_phase_a_own: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_07
    sample_upd_in |=> ##1 watt_inc_out[0] == $past(volt_in[0], 2) * $past(cur_in[0], 2))
    else $error("phase a watt increment not own product");

  chk_phase_b_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_08
    (s2_fire && consel_s1_reg == CONSEL_DELTA_3WIRE) |=> (watt_inc_out[1] == '0 && react_inc_out[1] == '0
      && fwatt_inc_out[1] == '0 && freact_inc_out[1] == '0 && apparent_inc_out[1] == '0))
    else $error("phase b not zero under three-wire delta");

  chk_phase_b_synth: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_09
    (sample_upd_in && consel_cur == CONSEL_WYE_2SENSOR)
      |=> watt_tot[1] == -($past(volt_in[0]) + $past(volt_in[2])) * $past(cur_in[1]))
    else $error("phase b voltage not minus sum of a and c");

  chk_phase_b_neg_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_10
    (sample_upd_in && consel_cur == CONSEL_DELTA_4WIRE) |=> watt_tot[1] == -$past(volt_in[0]) * $past(cur_in[1]))
    else $error("phase b voltage not minus va");

  chk_active_rev_src: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_11
    (s2_fire && revap_sel && fwatt_fed[0][33] != ap_prev_reg[0]) |=> status_reg[`STATUS_REVAP_A_BIT])
    else $error("fundamental active reversal flag not set");

  chk_react_rev_src: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_12
    (s2_fire && !revrp_sel && react_fed[2][33] != rp_prev_reg[2]) |=> status_reg[`STATUS_REVRP_A_BIT + 2])
    else $error("total reactive reversal flag not set");

  chk_cfg_no_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RULE_13
    (reg_wr_in && reg_addr_in == `ADDR_ACCUM_MODE_CFG && !s2_fire) |=> $stable(watt_inc_out[2]))
    else $error("config write disturbed accumulator feed");

endmodule // energy_accum_input_select

`default_nettype wire

// *** hw/accum_sel_consts.svh ***
// register offsets, field positions, reset values for the accumulator input selection
// assumes a 16-bit register address and 16-bit register data path
`ifndef ACCUM_SEL_CONSTS_SVH
`define ACCUM_SEL_CONSTS_SVH

// =====================================================
// offsets
`define ADDR_ACCUM_MODE_CFG   16'hE701
`define ADDR_PRIMARY_STATUS   16'hE710
`define ADDR_STATUS_MASK      16'hE711

// =====================================================
// reset values
`define CFG_RESET             8'h00
`define STATUS_RESET          16'h0000
`define MASK_RESET            16'h0000

// =====================================================
// accumulation_mode_config fields
`define CFG_WATT_LSB          0
`define CFG_WATT_MSB          1
`define CFG_VAR_LSB           2
`define CFG_VAR_MSB           3
`define CFG_CONSEL_LSB        4
`define CFG_CONSEL_MSB        5
`define CFG_REVAP_BIT         6
`define CFG_REVRP_BIT         7

// =====================================================
// primary_status_reg fields
`define STATUS_REVAP_A_BIT    6
`define STATUS_REVRP_A_BIT    10
`define STATUS_IMPL_MASK      16'h1DC0

`endif

// *** hw/accum_sel_pkg.sv ***
// types shared by the accumulator input selection block
// assumes 16-bit signed waveform samples from the dsp datapath
package accum_sel_pkg;

  typedef logic signed [15:0] sample_t;
  typedef logic signed [17:0] volt_ext_t;
  typedef logic signed [33:0] power_t;
  typedef logic        [15:0] rms_t;
  typedef logic        [31:0] apparent_t;

  typedef enum logic [1:0] {
    CONSEL_WYE_3SENSOR = 2'h0,
    CONSEL_DELTA_3WIRE = 2'h1,
    CONSEL_WYE_2SENSOR = 2'h2,
    CONSEL_DELTA_4WIRE = 2'h3
  } connection_select_t;

  typedef enum logic [1:0] {
    VARACC_SIGNED   = 2'h0,
    VARACC_RSV_1    = 2'h1,
    VARACC_BY_SIGN  = 2'h2,
    VARACC_RSV_3    = 2'h3
  } reactive_accum_mode_t;

endpackage

// *** hw/phase_power_if.sv ***
// bundle between the selection logic and one per-phase product stage
// assumes both ends share the dsp clock
`timescale 1ns/1ps
`default_nettype none

interface phase_power_if;
  import accum_sel_pkg::*;

  logic      upd;
  volt_ext_t v;
  sample_t   i;
  sample_t   iq;
  power_t    watt;
  power_t    react;
  logic      vld;

  modport calc (input upd, input v, input i, input iq, output watt, output react, output vld);
  modport feed (output upd, output v, output i, output iq, input watt, input react, input vld);
endinterface

`default_nettype wire

// *** hw/phase_power_calc.sv ***
// per-phase active and reactive product stage
// assumes inputs are stable in the cycle the update strobe is high
`timescale 1ns/1ps
`default_nettype none

module phase_power_calc
  import accum_sel_pkg::*;
(
  input  wire logic    clk_sys_in,
  input  wire logic    rstn_in,
  phase_power_if.calc  pp
);

  // =====================================================
  // products
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pp.watt  <= '0;
      pp.react <= '0;
    end else if (pp.upd) begin
      pp.watt  <= power_t'(pp.v) * power_t'(pp.i);
      pp.react <= power_t'(pp.v) * power_t'(pp.iq); // RULE_05
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pp.vld <= 1'b0;
    end else begin
      pp.vld <= pp.upd;
    end
  end

endmodule // phase_power_calc

`default_nettype wire

// *** sim/energy_accum_input_select_bench.sv ***
// self-checking bench for the accumulator input selection block
// assumes the register map of accum_sel_consts.svh and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "accum_sel_consts.svh"

module energy_accum_input_select_bench;
  import accum_sel_pkg::*;

  // ==================================================
  // signals
  logic        clk_sys_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [15:0] addr       = 16'h0000;
  logic [15:0] wdata      = 16'h0000;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [15:0] rdata;
  logic        irq;
  logic        upd        = 1'b0;
  logic        eupd;
  sample_t     v[3]   = '{16'sd100, 16'sd200, 16'sd300};
  sample_t     i[3]   = '{-16'sd10, 16'sd20, 16'sd30};
  sample_t     iq[3]  = '{16'sd5, 16'sd7, 16'sd9};
  sample_t     fv[3]  = '{16'sd50, 16'sd60, 16'sd70};
  sample_t     fi[3]  = '{16'sd3, 16'sd4, -16'sd5};
  sample_t     fiq[3] = '{16'sd2, -16'sd3, 16'sd4};
  rms_t        vr[3]  = '{16'h000B, 16'h000C, 16'h000D};
  rms_t        ir[3]  = '{16'h0002, 16'h0003, 16'h0004};
  power_t      w[3];
  power_t      fw[3];
  power_t      r[3];
  power_t      fr[3];
  apparent_t   ap[3];
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  energy_accum_input_select dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .sample_upd_in(upd), .volt_in(v), .cur_in(i), .cur_shift_in(iq), .fvolt_in(fv),
    .fcur_in(fi), .fcur_shift_in(fiq), .vrms_in(vr), .irms_in(ir), .energy_upd_out(eupd),
    .watt_inc_out(w), .fwatt_inc_out(fw), .react_inc_out(r), .freact_inc_out(fr),
    .apparent_inc_out(ap)
  );

  // ==================================================
  // helpers
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr    <= 1'b0;
  endtask

  task automatic bus_chk(input string name, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_in);
    rd   <= 1'b0;
    #1;
    chk(name, {18'h0, exp}, {18'h0, rdata});
  endtask

  task automatic do_upd();
    int n;
    n = 0;
    @(posedge clk_sys_in);
    upd <= 1'b1;
    @(posedge clk_sys_in);
    upd <= 1'b0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end while (eupd !== 1'b1 && n < 8);
    if (n >= 8) begin
      error_cnt++;
      $display("ERROR energy_upd expected 1 seen timeout");
      wrap_up();
    end
  endtask

  function automatic longint vsel(input int c, input int p, input longint a0, a1, a2);
    if (p != 1) return (p == 0) ? a0 : a2;
    case (c)
      0: return a1;
      2: return -(a0 + a2);
      3: return -a0;
      default: return 0;
    endcase
  endfunction

  // ==================================================
  // scenarios
  task automatic t_reset();
    bus_chk("cfg reset", `ADDR_ACCUM_MODE_CFG, {8'h00, `CFG_RESET});
    bus_chk("status reset", `ADDR_PRIMARY_STATUS, `STATUS_RESET);
    bus_chk("mask reset", `ADDR_STATUS_MASK, `MASK_RESET);
    bus_chk("unmapped", 16'h1234, 16'h0000);
    bus_wr(`ADDR_ACCUM_MODE_CFG, 16'hABF3);
    bus_chk("cfg upper ignored", `ADDR_ACCUM_MODE_CFG, 16'h00F3);
  endtask

  task automatic t_consel();
    longint b;
    for (int c = 0; c < 4; c++) begin
      bus_wr(`ADDR_ACCUM_MODE_CFG, 16'(c << 4));
      do_upd();
      for (int p = 0; p < 3; p++) begin
        b = vsel(c, p, v[0], v[1], v[2]);
        chk($sformatf("watt c%0d p%0d", c, p), 34'(b * i[p]), w[p]);
        chk($sformatf("react c%0d p%0d", c, p), 34'(b * iq[p]), r[p]);
        b = vsel(c, p, fv[0], fv[1], fv[2]);
        chk($sformatf("fwatt c%0d p%0d", c, p), 34'(b * fi[p]), fw[p]);
        chk($sformatf("freact c%0d p%0d", c, p), 34'(b * fiq[p]), fr[p]);
        b = (c == 1 && p == 1) ? 0 : longint'(vr[p]) * longint'(ir[p]);
        chk($sformatf("va c%0d p%0d", c, p), 34'(b), {2'b00, ap[p]});
      end
    end
  endtask

  task automatic t_varacc();
    longint s;
    for (int m = 0; m < 4; m++) begin
      bus_wr(`ADDR_ACCUM_MODE_CFG, 16'(m << 2));
      do_upd();
      s = (m == 2) ? -1 : 1;
      chk($sformatf("react a m%0d", m), 34'(s * v[0] * iq[0]), r[0]);
      chk($sformatf("react c m%0d", m), 34'(v[2] * iq[2]), r[2]);
      chk($sformatf("freact a m%0d", m), 34'(fv[0] * fiq[0]), fr[0]);
      chk($sformatf("freact c m%0d", m), 34'(s * fv[2] * fiq[2]), fr[2]);
    end
  endtask

  task automatic rev_case(input logic [15:0] cfg, input int sel, input logic [15:0] exp);
    bus_wr(`ADDR_ACCUM_MODE_CFG, cfg);
    do_upd();
    bus_wr(`ADDR_PRIMARY_STATUS, `STATUS_IMPL_MASK);
    @(posedge clk_sys_in);
    case (sel)
      0: i[0] <= -i[0];
      1: fi[0] <= -fi[0];
      2: iq[0] <= -iq[0];
      default: fiq[0] <= -fiq[0];
    endcase
    do_upd();
    repeat (2) @(posedge clk_sys_in);
    bus_chk($sformatf("status cfg %0h sel %0d", cfg, sel), `ADDR_PRIMARY_STATUS, exp);
  endtask

  task automatic t_reversal();
    rev_case(16'h0000, 0, 16'h0040);
    bus_wr(`ADDR_STATUS_MASK, 16'hFFFF);
    bus_chk("mask implemented", `ADDR_STATUS_MASK, `STATUS_IMPL_MASK);
    @(posedge clk_sys_in);
    #1;
    chk("irq unmasked", 34'h1, {33'h0, irq});
    bus_wr(`ADDR_STATUS_MASK, 16'h0400);
    @(posedge clk_sys_in);
    #1;
    chk("irq masked", 34'h0, {33'h0, irq});
    bus_wr(`ADDR_STATUS_MASK, 16'h0040);
    bus_wr(`ADDR_PRIMARY_STATUS, 16'h0040);
    @(posedge clk_sys_in);
    #1;
    chk("irq cleared", 34'h0, {33'h0, irq});
    rev_case(16'h0040, 0, 16'h0000);
    rev_case(16'h0040, 1, 16'h0040);
    rev_case(16'h0000, 2, 16'h0400);
    rev_case(16'h0080, 2, 16'h0000);
    rev_case(16'h0080, 3, 16'h0400);
  endtask

  // ==================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_consel();
    t_varacc();
    t_reversal();
    wrap_up();
  end
endmodule // energy_accum_input_select_bench

`default_nettype wire
